// [rtl/otw_pkg.sv]
// Shared constants and types for the overtravel warning and stop select block.
// Assumes a single 200 MHz control clock and an AXI4-Lite register bus.
`default_nettype none
package otw_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS = 5;
  localparam int DECEL_UNIT_NS = 1000000;
  localparam int CYC_PER_MS = DECEL_UNIT_NS / CLK_PERIOD_NS;

  // Register byte offsets.
  localparam logic [7:0] OFF_SETUP = 8'h00;
  localparam logic [7:0] OFF_APPLY = 8'h04;
  localparam logic [7:0] OFF_DECEL = 8'h08;
  localparam logic [7:0] OFF_ESTOP = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CLEAR = 8'h14;

  // Field positions inside the setup register.
  localparam int SETUP_STOP_LSB = 0;
  localparam int SETUP_OTSTOP_LSB = 4;
  localparam int SETUP_G2DEC_LSB = 8;
  localparam int SETUP_G2STOP_LSB = 12;
  localparam int SETUP_WARN_BIT = 16;

  // Values after reset.
  localparam logic [16:0] SETUP_RST = 17'h00002;
  localparam logic [13:0] DECEL_RST = 14'h0000;
  localparam logic [9:0] ESTOP_RST = 10'h320;

  // Setting limits.
  localparam logic [13:0] DECEL_MAX = 14'h2710;
  localparam logic [9:0] ESTOP_MAX = 10'h320;

  // Stop methods.
  typedef enum logic [2:0] {
    OTW_STOP_COAST = 3'h0,
    OTW_STOP_ZERO = 3'h1,
    OTW_STOP_TRQ = 3'h3,
    OTW_STOP_RAMP = 3'h2
  } otw_stop_t;

  // Stop sequencer states, Gray coded along run, stopping, held.
  typedef enum logic [1:0] {
    OTW_ST_RUN = 2'h0,
    OTW_ST_STOPPING = 2'h1,
    OTW_ST_HELD = 2'h3
  } otw_state_t;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// [rtl/otw_ramp.sv]
// Speed ramp that brings a speed reference to zero at a fixed slope.
// Assumes the span is at least max_speed cycles, so one step per cycle suffices.
`timescale 1ns/100ps
`default_nettype none
module otw_ramp #(
  parameter int SPD_W = 16,
  parameter int MAX_SPEED = 32767,
  parameter int CYC_PER_MS = otw_pkg::CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic signed [SPD_W-1:0] speed_i,
  input wire logic [13:0] decel_ms_i,
  output logic signed [SPD_W-1:0] speed_o,
  output logic done_o
);

  logic [31:0] acc_reg;
  logic [31:0] span;
  logic [31:0] acc_sum;

  // The span product must fit 32 bits and one step per cycle must suffice.
  if (MAX_SPEED >= CYC_PER_MS || CYC_PER_MS > 214748) begin : g_bad_param
    $error("otw_ramp: MAX_SPEED or CYC_PER_MS out of range");
  end

  // The slope is full speed over the whole set time, so a ramp from a lower
  // speed ends sooner than the set time.
  assign span = 32'(decel_ms_i) * 32'(CYC_PER_MS);
  assign acc_sum = acc_reg + 32'(MAX_SPEED);

  // Fractional accumulator steps the speed one unit whenever a span passes.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= 32'h0;
      speed_o <= '0;
    end else if (load_i) begin
      acc_reg <= 32'h0;
      speed_o <= speed_i;
    end else if (speed_o != '0) begin
      if (acc_sum >= span) begin
        acc_reg <= acc_sum - span;
        speed_o <= (speed_o > 0) ? speed_o - 1'b1 : speed_o + 1'b1;
      end else begin
        acc_reg <= acc_sum;
      end
    end
  end

  // Done is a flop of its own so the top sees a clean level.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_o <= 1'b1;
    end else begin
      done_o <= load_i ? (speed_i == '0) : (speed_o == '0);
    end
  end

endmodule
`default_nettype wire

// [rtl/otw_top.sv]
// Overtravel warning and stop method selection for a spindle servo drive.
// Assumes all pin inputs are synchronous to clk_i and software uses AXI4-Lite.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module otw_top #(
  parameter int ADDR_W = 8,
  parameter int SPD_W = 16,
  parameter int MAX_SPEED = 32767,
  parameter int CYC_PER_MS = otw_pkg::CYC_PER_MS,
  parameter int STILL_SPEED = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic forward_limit_input_i,
  input wire logic reverse_limit_input_i,
  input wire logic servo_on_i,
  input wire logic ref_fwd_i,
  input wire logic ref_rev_i,
  input wire logic torque_mode_i,
  input wire logic alarm_g1_i,
  input wire logic alarm_g2_i,
  input wire logic fault_clear_command_i,
  input wire logic signed [SPD_W-1:0] speed_cmd_i,
  input wire logic signed [SPD_W-1:0] motor_speed_i,
  output logic ot_warning_o,
  output logic drive_enable_o,
  output logic zero_clamp_o,
  output logic stop_active_o,
  output logic signed [SPD_W-1:0] speed_ref_o,
  output logic [9:0] torque_limit_o
);

  // Refuse values that the decode and compare logic cannot serve.
  if (ADDR_W < 5 || ADDR_W > 8 || SPD_W < 8
      || STILL_SPEED < 0) begin : g_bad_param
    $error("otw_top: parameter out of range");
  end

  logic [16:0] setup_reg;
  logic [16:0] setup_act_reg;
  logic [13:0] decel_reg;
  logic [9:0] estop_reg;
  logic clr_sw_reg;
  logic warn_reg;
  logic block_reg;
  logic any_ot_q_reg;
  logic servo_q_reg;
  otw_pkg::otw_state_t st_reg;
  otw_pkg::otw_stop_t kind_reg;
  logic clamp_after_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Limit inputs are drive enables: low means that direction is prohibited.
  logic fwd_ot;
  logic rev_ot;
  logic any_ot;
  logic hit;
  logic clear;
  logic raise;
  assign fwd_ot = !forward_limit_input_i;
  assign rev_ot = !reverse_limit_input_i;
  assign any_ot = fwd_ot | rev_ot;

  // Only overtravel in the direction of travel counts; idle accepts both.
  assign hit = (ref_fwd_i & fwd_ot)
             | (ref_rev_i & rev_ot)
             | (!ref_fwd_i & !ref_rev_i & any_ot);
  assign clear = fault_clear_command_i | clr_sw_reg;
  // The software limit is deliberately not an input here.
  // The servo-on cycle itself never raises: a limit that arrives with it
  // counts as already present.
  assign raise = setup_act_reg[otw_pkg::SETUP_WARN_BIT] & servo_on_i
               & servo_q_reg & hit & !block_reg;

  // Warning flag: sampled every cycle so a one-cycle limit pulse is caught.
  // During a clear only a fresh onset may set it, so set beats clear.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warn_reg <= 1'b0;
    end else if (clear) begin
      warn_reg <= raise & !any_ot_q_reg;
    end else if (raise) begin
      warn_reg <= 1'b1;
    end
  end

  // Block stops a limit already present at servo on or at a clear from
  // raising the warning until every limit has been left.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      block_reg <= 1'b0;
      any_ot_q_reg <= 1'b0;
      servo_q_reg <= 1'b0;
    end else begin
      any_ot_q_reg <= any_ot;
      servo_q_reg <= servo_on_i;
      if (!servo_on_i || !servo_q_reg || clear) begin
        block_reg <= any_ot;
      end else if (!any_ot) begin
        block_reg <= 1'b0;
      end
    end
  end

  // Decodes a method digit that may ask for torque or timed deceleration.
  // A zero deceleration time turns the timed ramp into a zero-speed stop.
  function automatic otw_pkg::otw_stop_t decel_kind(input logic [3:0] d,
                                                    input logic [13:0] t);
    otw_pkg::otw_stop_t k;
    k = otw_pkg::OTW_STOP_COAST;
    if (d == 4'h1 || d == 4'h2) begin
      k = otw_pkg::OTW_STOP_TRQ;
    end else if (d == 4'h3 || d == 4'h4) begin
      k = (t == 14'h0) ? otw_pkg::OTW_STOP_ZERO
                       : otw_pkg::OTW_STOP_RAMP;
    end
    return k;
  endfunction

  // Stop request and its method. Priority: group 1 and servo off, group 2,
  // overtravel. Group 1 and servo off only have coasting codes in use.
  logic ot_stop;
  logic stop_req;
  otw_pkg::otw_stop_t dec_kind;
  logic dec_clamp;
  logic [3:0] ot_digit;
  logic [3:0] g2_stop;
  assign ot_stop = (ref_fwd_i & fwd_ot) | (ref_rev_i & rev_ot);
  assign stop_req = alarm_g1_i | alarm_g2_i | !servo_on_i | ot_stop;
  assign ot_digit = setup_act_reg[otw_pkg::SETUP_OTSTOP_LSB +: 4];
  assign g2_stop = setup_act_reg[otw_pkg::SETUP_G2STOP_LSB +: 4];
  always_comb begin
    dec_kind = otw_pkg::OTW_STOP_COAST;
    dec_clamp = 1'b0;
    if (alarm_g1_i || !servo_on_i || (alarm_g2_i && torque_mode_i)) begin
      dec_kind = otw_pkg::OTW_STOP_COAST;
    end else if (alarm_g2_i) begin
      if (g2_stop == 4'h0) begin
        dec_kind = otw_pkg::OTW_STOP_ZERO;
      end else if (g2_stop == 4'h2) begin
        dec_kind = decel_kind(setup_act_reg[otw_pkg::SETUP_G2DEC_LSB +: 4],
                              decel_reg);
      end
    end else if (!torque_mode_i) begin
      dec_kind = decel_kind(ot_digit, decel_reg);
      dec_clamp = (ot_digit == 4'h1) || (ot_digit == 4'h3);
    end
  end

  // Stop sequencer. The method is latched on entry; a later alarm does not
  // re-plan a stop already under way, which keeps the ramp monotonic.
  logic still;
  logic ramp_load;
  logic ramp_done;
  logic signed [SPD_W-1:0] ramp_speed;
  assign still = (motor_speed_i <= SPD_W'(STILL_SPEED))
              && (motor_speed_i >= -SPD_W'(STILL_SPEED));
  assign ramp_load = (st_reg == otw_pkg::OTW_ST_RUN) && stop_req;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= otw_pkg::OTW_ST_HELD;
      kind_reg <= otw_pkg::OTW_STOP_COAST;
      clamp_after_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        otw_pkg::OTW_ST_RUN: begin
          if (stop_req) begin
            st_reg <= otw_pkg::OTW_ST_STOPPING;
            kind_reg <= dec_kind;
            clamp_after_reg <= dec_clamp;
          end
        end
        otw_pkg::OTW_ST_STOPPING: begin
          if (!stop_req) begin
            st_reg <= otw_pkg::OTW_ST_RUN;
          end else if (still && (kind_reg != otw_pkg::OTW_STOP_RAMP
                                 || ramp_done)) begin
            st_reg <= otw_pkg::OTW_ST_HELD;
          end
        end
        otw_pkg::OTW_ST_HELD: begin
          if (!stop_req) begin
            st_reg <= otw_pkg::OTW_ST_RUN;
          end
        end
        default: st_reg <= otw_pkg::OTW_ST_HELD;
      endcase
    end
  end

  // Timed deceleration ramp, restarted from the present reference.
  otw_ramp #(
    .SPD_W(SPD_W),
    .MAX_SPEED(MAX_SPEED),
    .CYC_PER_MS(CYC_PER_MS)
  ) i_otw_ramp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(ramp_load),
    .speed_i(speed_ref_o),
    .decel_ms_i(decel_reg),
    .speed_o(ramp_speed),
    .done_o(ramp_done)
  );

  // Drive outputs. The warning never appears here: it is only reported.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_enable_o <= 1'b0;
      zero_clamp_o <= 1'b0;
      stop_active_o <= 1'b0;
      speed_ref_o <= '0;
      torque_limit_o <= otw_pkg::ESTOP_MAX;
    end else begin
      stop_active_o <= (st_reg != otw_pkg::OTW_ST_RUN);
      zero_clamp_o <= 1'b0;
      speed_ref_o <= '0;
      torque_limit_o <= otw_pkg::ESTOP_MAX;
      drive_enable_o <= 1'b1;
      unique case (st_reg)
        otw_pkg::OTW_ST_RUN: begin
          speed_ref_o <= speed_cmd_i;
        end
        otw_pkg::OTW_ST_STOPPING: begin
          unique case (kind_reg)
            otw_pkg::OTW_STOP_COAST: drive_enable_o <= 1'b0;
            otw_pkg::OTW_STOP_ZERO: speed_ref_o <= '0;
            otw_pkg::OTW_STOP_TRQ: torque_limit_o <= estop_reg;
            otw_pkg::OTW_STOP_RAMP: speed_ref_o <= ramp_speed;
            default: drive_enable_o <= 1'b0;
          endcase
        end
        otw_pkg::OTW_ST_HELD: begin
          drive_enable_o <= clamp_after_reg;
          zero_clamp_o <= clamp_after_reg;
        end
        default: drive_enable_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ot_warning_o <= 1'b0;
    end else begin
      ot_warning_o <= warn_reg;
    end
  end

  // Address decode shared by the write and read paths.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a,
                                     input logic wr);
    logic [7:0] o;
    o = 8'(a);
    return (o == otw_pkg::OFF_SETUP) || (o == otw_pkg::OFF_DECEL)
        || (o == otw_pkg::OFF_ESTOP) || (wr && o == otw_pkg::OFF_APPLY)
        || (wr && o == otw_pkg::OFF_CLEAR) || (!wr && o == otw_pkg::OFF_STATUS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Write channel capture; address and data may arrive in either order.
  logic do_write;
  logic [7:0] wr_off;
  logic [31:0] wr_val;
  assign do_write = aw_full_reg & w_full_reg & !s_axi_bvalid_o;
  assign wr_off = 8'(aw_addr_reg);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= otw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= is_mapped(aw_addr_reg, 1'b1) ? otw_pkg::RESP_OKAY
                                                      : otw_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Register writes. Setup fields wait for an apply, which stands for the
  // drive restart; the times and torque take effect at once, saturated.
  assign wr_val = merge(32'h0, w_data_reg, w_strb_reg);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      setup_reg <= otw_pkg::SETUP_RST;
      setup_act_reg <= otw_pkg::SETUP_RST;
      decel_reg <= otw_pkg::DECEL_RST;
      estop_reg <= otw_pkg::ESTOP_RST;
      clr_sw_reg <= 1'b0;
    end else begin
      clr_sw_reg <= do_write && wr_off == otw_pkg::OFF_CLEAR && wr_val[0];
      if (do_write && wr_off == otw_pkg::OFF_SETUP) begin
        setup_reg <= 17'(merge(32'(setup_reg), w_data_reg, w_strb_reg));
      end
      if (do_write && wr_off == otw_pkg::OFF_APPLY && wr_val[0]) begin
        setup_act_reg <= setup_reg;
      end
      if (do_write && wr_off == otw_pkg::OFF_DECEL) begin
        decel_reg <= (wr_val[15:0] > 16'(otw_pkg::DECEL_MAX))
                     ? otw_pkg::DECEL_MAX : wr_val[13:0];
      end
      if (do_write && wr_off == otw_pkg::OFF_ESTOP) begin
        estop_reg <= (wr_val[15:0] > 16'(otw_pkg::ESTOP_MAX))
                     ? otw_pkg::ESTOP_MAX : wr_val[9:0];
      end
    end
  end

  // Read channel: one-cycle answer after the address is taken.
  logic [31:0] rd_val;
  always_comb begin
    unique case (8'(s_axi_araddr_i))
      otw_pkg::OFF_SETUP: rd_val = 32'(setup_reg);
      otw_pkg::OFF_DECEL: rd_val = 32'(decel_reg);
      otw_pkg::OFF_ESTOP: rd_val = 32'(estop_reg);
      otw_pkg::OFF_STATUS: rd_val = {22'h0, drive_enable_o, zero_clamp_o,
                                     st_reg, kind_reg, rev_ot, fwd_ot,
                                     warn_reg};
      default: rd_val = 32'h0;
    endcase
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= otw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_val;
      s_axi_rresp_o <= is_mapped(s_axi_araddr_i, 1'b0) ? otw_pkg::RESP_OKAY
                                                       : otw_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // Checks on the warning and stop logic.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_warn_needs_on: assert property ($rose(warn_reg) |-> $past(servo_on_i)
      && $past(setup_act_reg[16])) else $error("warning rose off");
  a_warn_dir: assert property ($rose(warn_reg) |-> $past(hit))
      else $error("warning for wrong direction");
  a_warn_raise: assert property (raise && !clear |=> warn_reg ##1 ot_warning_o)
      else $error("warning not raised");
  a_warn_sticky: assert property (warn_reg && !clear |=> warn_reg)
      else $error("warning dropped without clear");
  a_warn_clear: assert property (clear && any_ot_q_reg |=> !warn_reg)
      else $error("warning not cleared");
  a_servo_edge: assert property (!servo_on_i ##1 servo_on_i && any_ot
      && !warn_reg |=> !warn_reg) else $error("warning at servo on");
  a_zero_time: assert property (decel_reg == 14'h0 |->
      dec_kind != otw_pkg::OTW_STOP_RAMP) else $error("ramp at zero");
  a_torque_g2: assert property (alarm_g2_i && torque_mode_i |->
      dec_kind == otw_pkg::OTW_STOP_COAST) else $error("g2 in torque");
  a_coast_off: assert property (st_reg == otw_pkg::OTW_ST_STOPPING
      && kind_reg == otw_pkg::OTW_STOP_COAST |=> !drive_enable_o)
      else $error("coast still driving");
  a_trq_cap: assert property (st_reg == otw_pkg::OTW_ST_STOPPING
      && kind_reg == otw_pkg::OTW_STOP_TRQ |=>
      torque_limit_o == $past(estop_reg)) else $error("torque cap");

  c_warn_raise: cover property ($rose(ot_warning_o));
  c_clear_in_ot: cover property (clear && any_ot ##1 !warn_reg ##3 !any_ot);
  c_ramp_stop: cover property (st_reg == otw_pkg::OTW_ST_STOPPING
      && kind_reg == otw_pkg::OTW_STOP_RAMP ##[1:1000] st_reg ==
      otw_pkg::OTW_ST_HELD);

endmodule
`default_nettype wire

// [tb/otw_limits.sv]
// Limit switch model for the forward and reverse limit inputs.
// Assumes the bench drives trip requests just after rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module otw_limits (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic trip_f_i,
  input wire logic trip_r_i,
  output logic fwd_o,
  output logic rev_o
);
  // Normally closed switches read high while travel is allowed.
  // A broken wire also reads as overtravel, which is the safe side.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fwd_o <= 1'b1;
      rev_o <= 1'b1;
    end else begin
      fwd_o <= !trip_f_i;
      rev_o <= !trip_r_i;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_otw_top.sv]
// Self-checking bench for the overtravel warning and stop select block.
// Assumes the limit model otw_limits and the design package otw_pkg.
`timescale 1ns/100ps
`default_nettype none
module tb_otw_top;
  logic clk_i = 0, resetn_i = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic arvalid = 0, rready = 0, trip_f = 0, trip_r = 0, servo = 0;
  logic rf = 0, rr = 0, tq = 0, g1 = 0, g2 = 0, clr = 0;
  logic [31:0] wdata = 0, rdata, r;
  logic awready, wready, bvalid, arready, rvalid, fwd, rev, warn, drv, stp;
  logic [1:0] bresp, rresp, rs;
  logic signed [15:0] sref;
  logic signed [15:0] mspd = 16'sh0064;
  logic zc;
  logic [9:0] tlim;
  int error_cnt = 0, checks = 0, cyc = 0;
  logic [31:0] cfg [7] = '{32'h10002, 32'h10002, 32'h10002, 32'h11002,
    32'h12302, 32'h12002, 32'h12102};
  logic [2:0] mode [7] = '{3'h1, 3'h4, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1};
  // The 200 MHz control clock, 5 ns period.
  always #2.5 clk_i = ~clk_i;
  otw_limits i_otw_limits (.clk_i(clk_i), .resetn_i(resetn_i),
    .trip_f_i(trip_f), .trip_r_i(trip_r), .fwd_o(fwd), .rev_o(rev));
  // Short millisecond so timed stops stay brief in simulation.
  otw_top #(.MAX_SPEED(50), .CYC_PER_MS(100)) i_otw_top (.clk_i(clk_i),
    .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .forward_limit_input_i(fwd), .reverse_limit_input_i(rev),
    .servo_on_i(servo), .ref_fwd_i(rf), .ref_rev_i(rr), .torque_mode_i(tq),
    .alarm_g1_i(g1), .alarm_g2_i(g2), .fault_clear_command_i(clr),
    .speed_cmd_i(16'sh0014), .motor_speed_i(mspd), .ot_warning_o(warn),
    .drive_enable_o(drv), .zero_clamp_o(zc), .stop_active_o(stp),
    .speed_ref_o(sref), .torque_limit_o(tlim));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Address and data are offered together and each is dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    r = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic trip(input logic tf, input logic tr, input int n);
    trip_f <= tf;
    trip_r <= tr;
    cy(n);
    trip_f <= 1'b0;
    trip_r <= 1'b0;
    cy(5);
  endtask
  task automatic clear_pin;
    clr <= 1'b1;
    cy(1);
    clr <= 1'b0;
    cy(4);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A hung handshake would stall forever, so a cycle ceiling ends the run.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    cy(3);
    resetn_i <= 1'b1;
    rd(otw_pkg::OFF_SETUP);
    chk(r, 32'h00002);
    rd(otw_pkg::OFF_ESTOP);
    chk(r, 32'h320);
    wr(otw_pkg::OFF_DECEL, 32'hffff);
    chk(rs, otw_pkg::RESP_OKAY);
    rd(otw_pkg::OFF_DECEL);
    chk(r, 32'h2710);
    wr(otw_pkg::OFF_ESTOP, 32'h3ff);
    rd(otw_pkg::OFF_ESTOP);
    chk(r, 32'h320);
    rd(8'h18);
    chk(rs, otw_pkg::RESP_SLVERR);
    wr(otw_pkg::OFF_STATUS, 32'h1);
    chk(rs, otw_pkg::RESP_SLVERR);
    wr(otw_pkg::OFF_DECEL, 32'h0);
    $display("test registers done");
    servo <= 1'b1;
    trip(1'b1, 1'b0, 1);
    wr(otw_pkg::OFF_SETUP, 32'h10002);
    trip(1'b1, 1'b0, 1);
    chk(warn, 1'b0);
    wr(otw_pkg::OFF_APPLY, 32'h1);
    rf <= 1'b1;
    trip(1'b0, 1'b1, 3);
    chk(warn, 1'b0);
    trip(1'b1, 1'b0, 1);
    chk(warn, 1'b1);
    chk(stp, 1'b0);
    chk(sref, 32'h14);
    clear_pin();
    chk(warn, 1'b0);
    trip_f <= 1'b1;
    cy(6);
    chk(stp, 1'b1);
    clear_pin();
    chk(warn, 1'b0);
    trip(1'b0, 1'b0, 1);
    trip(1'b1, 1'b0, 1);
    chk(warn, 1'b1);
    rf <= 1'b0;
    wr(otw_pkg::OFF_CLEAR, 32'h1);
    cy(3);
    chk(warn, 1'b0);
    trip(1'b0, 1'b1, 1);
    chk(warn, 1'b1);
    wr(otw_pkg::OFF_CLEAR, 32'h1);
    servo <= 1'b0;
    trip(1'b1, 1'b0, 3);
    chk(warn, 1'b0);
    trip_f <= 1'b1;
    cy(3);
    servo <= 1'b1;
    trip(1'b1, 1'b0, 5);
    chk(warn, 1'b0);
    $display("test warning done");
    // Rows give setup word, then torque mode, group 1 and expected drive.
    for (int i = 0; i < 7; i++) begin
      wr(otw_pkg::OFF_SETUP, cfg[i]);
      wr(otw_pkg::OFF_APPLY, 32'h1);
      tq <= mode[i][2];
      g1 <= mode[i][1];
      g2 <= !mode[i][1];
      cy(6);
      chk(drv, mode[i][0]);
      if (mode[i][0]) chk(sref, 32'h0);
      tq <= 1'b0;
      g1 <= 1'b0;
      g2 <= 1'b0;
      cy(6);
    end
    // Overtravel stop by torque with clamp, then by time with coasting.
    wr(otw_pkg::OFF_ESTOP, 32'h64);
    wr(otw_pkg::OFF_SETUP, 32'h10012);
    wr(otw_pkg::OFF_APPLY, 32'h1);
    rf <= 1'b1;
    trip_f <= 1'b1;
    cy(6);
    chk(tlim, 32'h64);
    mspd <= 16'sh0000;
    cy(6);
    chk({zc, drv}, 32'h3);
    rd(otw_pkg::OFF_STATUS);
    chk(r, 32'h3db);
    trip_f <= 1'b0;
    rf <= 1'b0;
    mspd <= 16'sh0064;
    cy(6);
    chk({zc, stp}, 32'h0);
    wr(otw_pkg::OFF_DECEL, 32'h1);
    wr(otw_pkg::OFF_SETUP, 32'h10042);
    wr(otw_pkg::OFF_APPLY, 32'h1);
    rf <= 1'b1;
    trip_f <= 1'b1;
    cy(12);
    chk(sref > 0 && sref < 16'sh0014, 1'b1);
    cy(60);
    chk({drv, sref}, {1'b1, 16'sh0000});
    mspd <= 16'sh0000;
    cy(6);
    chk(drv, 1'b0);
    trip_f <= 1'b0;
    rf <= 1'b0;
    mspd <= 16'sh0064;
    $display("test stop methods done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
